// File: rtl/dmd_cfg.svh
// Opcodes, field codes and clock counts of the data-move decoder
`ifndef DMD_CFG_SVH
`define DMD_CFG_SVH
`define DMD_OP_SEG_LOAD    8'h8E
`define DMD_OP_SEG_STORE   8'h8C
`define DMD_OP_TABLE_LOOK  8'hD7
`define DMD_OP_LOAD_OFS    8'h8D
`define DMD_OP_FAR_DATA    8'hC5
`define DMD_OP_FAR_EXTRA   8'hC4
`define DMD_OP_FLAGS_TO_HI 8'h9F
`define DMD_OP_HI_TO_FLAGS 8'h9E
`define DMD_OP_PUSH_FLAGS  8'h9C
`define DMD_OP_POP_FLAGS   8'h9D
`define DMD_OP_PUSH_ALL    8'h60
`define DMD_OP_POP_ALL     8'h61
`define DMD_SEG_EXTRA      2'h0
`define DMD_SEG_CODE       2'h1
`define DMD_SEG_STACK      2'h2
`define DMD_SEG_DATA       2'h3
`define DMD_FORM_REG       2'h3
`define DMD_FORM_DISP8     2'h1
`define DMD_FORM_DISP16    2'h2
`define DMD_RM_DIRECT      3'h6
`define DMD_WORD_PENALTY   8'h04
`define DMD_OFS_CLOCKS     8'h04
`endif

// File: rtl/dmd_pkg.sv
// Types shared by the data-move decoder
package dmd_pkg;
    typedef enum logic [1:0] {
        DMD_ST_OP   = 2'b00,
        DMD_ST_MODRM = 2'b01,
        DMD_ST_DISP = 2'b11,
        DMD_ST_DONE = 2'b10
    } dmd_state_t;

    typedef struct packed {
        logic [2:0]  cls;      // Instruction class code
        logic        word;     // Size flag
        logic        has_modrm;
        logic        is_mem;
        logic [7:0]  clocks;   // Execution clocks incl. word penalty
        logic        valid;
    } dmd_decode_t;

    typedef struct packed {
        logic [15:0] bx;
        logic [15:0] base_ptr;
        logic [15:0] si;
        logic [15:0] dest_idx;
    } dmd_regs_t;
endpackage

// File: rtl/dmd_addr_gen.sv
// Operand offset and segment selection from addressing form and selector
`timescale 1ns/1ns
`include "dmd_cfg.svh"
module dmd_addr_gen (
    input  wire logic [1:0]       form_in,      // Addressing form
    input  wire logic [2:0]       sel_in,       // Operand selector
    input  wire logic [15:0]      disp_in,      // Raw displacement bytes
    input  wire dmd_pkg::dmd_regs_t regs_in,    // Base and index registers
    input  wire logic             ovr_in,       // Override present
    input  wire logic [1:0]       ovr_seg_in,   // Override segment
    input  wire logic             string_in,    // String destination operand
    output logic [15:0]           offset_out,   // Operand offset
    output logic [1:0]            seg_out       // Effective segment
);
    import dmd_pkg::*;

    logic [15:0] base;
    logic [15:0] disp;
    logic        uses_base;
    always_comb begin
        unique case (form_in)
            2'h0:    disp = 16'h0000;
            2'h1:    disp = {{8{disp_in[7]}}, disp_in[7:0]};
            default: disp = disp_in;
        endcase
        uses_base = 1'b0;
        unique case (sel_in)
            3'h0: base = regs_in.bx + regs_in.si;
            3'h1: base = regs_in.bx + regs_in.dest_idx;
            3'h2: begin base = regs_in.base_ptr + regs_in.si; uses_base = 1'b1; end
            3'h3: begin base = regs_in.base_ptr + regs_in.dest_idx; uses_base = 1'b1; end
            3'h4: base = regs_in.si;
            3'h5: base = regs_in.dest_idx;
            3'h6: begin base = regs_in.base_ptr; uses_base = 1'b1; end
            3'h7: base = regs_in.bx;
        endcase
        // Direct address form has no base at all
        if (form_in == 2'h0 && sel_in == `DMD_RM_DIRECT) begin
            base = 16'h0000;
            disp = disp_in;
            uses_base = 1'b0;
        end
        offset_out = base + disp;
        if (string_in)
            seg_out = `DMD_SEG_EXTRA;
        else if (ovr_in)
            seg_out = ovr_seg_in;
        else if (uses_base)
            seg_out = `DMD_SEG_STACK;
        else
            seg_out = `DMD_SEG_DATA;
    end
endmodule

// File: rtl/dmd_decoder.sv
// Data-transfer instruction decoder with prefix, field and timing decode
`timescale 1ns/1ns
`include "dmd_cfg.svh"
module dmd_decoder (
    input  wire logic               core_clk_in,   // Core clock, 100 MHz
    input  wire logic               rst_in,        // Async reset, active high
    input  wire logic               byte_valid_in, // Instruction byte offered
    input  wire logic [7:0]         byte_in,       // Instruction byte
    input  wire dmd_pkg::dmd_regs_t regs_in,       // Address registers
    output logic                    byte_ready_out,// Byte consumed
    output logic                    done_out,      // Decode result valid, one cycle
    output dmd_pkg::dmd_decode_t    decode_out,    // Decode result
    output logic [7:0]              opcode_out,    // Opcode byte
    output logic [3:0]              reg_code_out,  // {size, register field}
    output logic [1:0]              seg_out,       // Effective operand segment
    output logic [15:0]             offset_out,    // Operand offset
    output logic                    illegal_out    // Undefined form seen
);
    import dmd_pkg::*;

    typedef struct packed {
        dmd_state_t  st;
        logic [7:0]  op;
        logic [7:0]  modrm;
        logic [15:0] disp;
        logic [1:0]  ndisp;
        logic        ovr;
        logic [1:0]  ovr_seg;
        dmd_decode_t dec;
        logic [15:0] offset;
        logic [1:0]  seg;
        logic        done;
        logic        illegal;
    } dmd_core_t;

    dmd_core_t s_r;
    dmd_core_t s_nxt;
    logic [15:0] ag_offset;
    logic [1:0]  ag_seg;
    logic        string_dst;

    // Size, base clocks, validity and modrm presence of one opcode
    function automatic dmd_decode_t classify(input logic [7:0] op);
        dmd_decode_t d;
        d = '0;
        d.valid = 1'b1;
        d.word  = op[0];
        unique casez (op)
            `DMD_OP_SEG_LOAD, `DMD_OP_SEG_STORE, `DMD_OP_LOAD_OFS,
            `DMD_OP_FAR_DATA, `DMD_OP_FAR_EXTRA: begin
                d.has_modrm = 1'b1;
                d.word = 1'b1;
            end
            8'b1000_10??, 8'b1000_011?, 8'b1100_011?, 8'h8F, 8'hFF:
                d.has_modrm = 1'b1;
            `DMD_OP_TABLE_LOOK:  d.clocks = 8'd15;
            `DMD_OP_FLAGS_TO_HI: d.clocks = 8'd2;
            `DMD_OP_HI_TO_FLAGS: d.clocks = 8'd3;
            `DMD_OP_PUSH_FLAGS:  d.clocks = 8'd13;
            `DMD_OP_POP_FLAGS:   d.clocks = 8'd12;
            `DMD_OP_PUSH_ALL:    d.clocks = 8'd68;
            `DMD_OP_POP_ALL:     d.clocks = 8'd83;
            8'b0110_10?1:        d.clocks = 8'd14;
            8'b1011_????:        begin d.word = op[3]; d.clocks = op[3] ? 8'd4 : 8'd3; end
            8'b1010_000?:        d.clocks = 8'd8;
            8'b1010_001?:        d.clocks = 8'd9;
            8'b0101_????:        begin d.word = 1'b1; d.clocks = 8'd14; end
            8'b000?_?110:        begin d.word = 1'b1; d.clocks = 8'd13; end
            // The code segment cannot be popped
            8'b000?_?111:        begin
                d.word = 1'b1;
                d.clocks = 8'd12;
                d.valid = (op[4:3] != 2'b01);
            end
            8'b1001_0???:        begin d.word = 1'b1; d.clocks = 8'd3; end
            8'b1110_010?:        d.clocks = 8'd10;
            8'b1110_110?:        d.clocks = 8'd8;
            8'b1110_011?:        d.clocks = 8'd9;
            8'b1110_111?:        d.clocks = 8'd7;
            default:             d.valid = 1'b0;
        endcase
        return d;
    endfunction

    // Clocks once the addressing form is known; offset time is inside these
    function automatic logic [7:0] form_clocks(input logic [7:0] op, input logic mem,
                                               input logic w);
        logic [7:0] c;
        c = 8'd0;
        unique casez (op)
            `DMD_OP_SEG_LOAD:  c = mem ? 8'd13 : 8'd2;
            `DMD_OP_SEG_STORE: c = mem ? 8'd15 : 8'd2;
            `DMD_OP_LOAD_OFS:  c = 8'd6;
            `DMD_OP_FAR_DATA, `DMD_OP_FAR_EXTRA: c = 8'd26;
            8'b1000_100?:      c = mem ? 8'd12 : 8'd2;
            8'b1000_101?:      c = mem ? 8'd9 : 8'd2;
            8'b1000_011?:      c = mem ? 8'd17 : 8'd4;
            8'b1100_011?:      c = w ? 8'd13 : 8'd12;
            8'hFF:             c = 8'd20;
            8'h8F:             c = 8'd24;
            default:           c = 8'd0;
        endcase
        return c;
    endfunction

    // Word moves 88-8B and exchanges 86/87 with a memory operand, accumulator moves A0-A3 and port ops E4-E7/EC-EF pay the bus penalty
    function automatic logic pays_penalty(input logic [7:0] op, input logic mem);
        logic p;
        p = 1'b0;
        unique casez (op)
            8'b1000_10??, 8'b1000_011?: p = mem;
            8'b1010_00??, 8'b1110_?1??: p = 1'b1;
            default:                    p = 1'b0;
        endcase
        return p;
    endfunction

    // String stores/moves write through dest_index
    assign string_dst = (s_r.op[7:1] == 7'b1010_010) || (s_r.op[7:1] == 7'b1010_101);

    dmd_addr_gen u_addr (
        .form_in    (s_r.modrm[7:6]),
        .sel_in     (s_r.modrm[2:0]),
        .disp_in    (s_r.disp),
        .regs_in    (regs_in),
        .ovr_in     (s_r.ovr),
        .ovr_seg_in (s_r.ovr_seg),
        .string_in  (string_dst),
        .offset_out (ag_offset),
        .seg_out    (ag_seg)
    );

    always_comb begin
        logic        mem;
        dmd_decode_t d;
        mem = 1'b0;
        d = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        byte_ready_out = (s_r.st != DMD_ST_DONE);
        unique case (s_r.st)
            DMD_ST_OP: if (byte_valid_in) begin
                if (byte_in[7:5] == 3'b001 && byte_in[2:0] == 3'b110) begin
                    s_nxt.ovr = 1'b1;
                    s_nxt.ovr_seg = byte_in[4:3];
                end else begin
                    s_nxt.op = byte_in;
                    s_nxt.dec = classify(byte_in);
                    s_nxt.modrm = '0;
                    s_nxt.disp = '0;
                    s_nxt.st = s_nxt.dec.has_modrm ? DMD_ST_MODRM : DMD_ST_DONE;
                end
            end
            DMD_ST_MODRM: if (byte_valid_in) begin
                s_nxt.modrm = byte_in;
                mem = (byte_in[7:6] != `DMD_FORM_REG);
                s_nxt.dec.is_mem = mem;
                s_nxt.dec.clocks = form_clocks(s_r.op, mem, s_r.dec.word);
                if (byte_in[7:6] == `DMD_FORM_DISP8)
                    s_nxt.ndisp = 2'd1;
                else if (byte_in[7:6] == `DMD_FORM_DISP16 ||
                         (byte_in[7:6] == 2'h0 && byte_in[2:0] == `DMD_RM_DIRECT))
                    s_nxt.ndisp = 2'd2;
                else
                    s_nxt.ndisp = 2'd0;
                // Far pointer loads need a memory operand
                if ((s_r.op == `DMD_OP_FAR_DATA || s_r.op == `DMD_OP_FAR_EXTRA) && !mem)
                    s_nxt.dec.valid = 1'b0;
                // Segment load/store carry a zero before the segment code
                if ((s_r.op == `DMD_OP_SEG_LOAD || s_r.op == `DMD_OP_SEG_STORE)
                    && byte_in[5])
                    s_nxt.dec.valid = 1'b0;
                s_nxt.st = (s_nxt.ndisp != 2'd0) ? DMD_ST_DISP : DMD_ST_DONE;
            end
            DMD_ST_DISP: if (byte_valid_in) begin
                // Low byte first, then high byte
                if (s_r.ndisp == 2'd1 && s_r.modrm[7:6] != `DMD_FORM_DISP8)
                    s_nxt.disp[15:8] = byte_in;
                else
                    s_nxt.disp[7:0] = byte_in;
                s_nxt.ndisp = (s_r.modrm[7:6] == `DMD_FORM_DISP8) ? 2'd0 : s_r.ndisp - 2'd1;
                if (s_nxt.ndisp == 2'd0)
                    s_nxt.st = DMD_ST_DONE;
            end
            DMD_ST_DONE: begin
                d = s_r.dec;
                if (d.word && pays_penalty(s_r.op, d.is_mem))
                    d.clocks = d.clocks + `DMD_WORD_PENALTY;
                s_nxt.dec = d;
                s_nxt.offset = (s_r.op == `DMD_OP_LOAD_OFS || d.is_mem) ? ag_offset : 16'h0000;
                s_nxt.seg = ag_seg;
                s_nxt.illegal = !d.valid;
                s_nxt.done = 1'b1;
                s_nxt.ovr = 1'b0;
                s_nxt.st = DMD_ST_OP;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign done_out     = s_r.done;
    assign decode_out   = s_r.dec;
    assign opcode_out   = s_r.op;
    assign reg_code_out = {s_r.dec.word, s_r.modrm[5:3]};
    assign seg_out      = s_r.seg;
    assign offset_out   = s_r.offset;
    assign illegal_out  = s_r.illegal;

    property p_seg_force;
        @(posedge core_clk_in) disable iff (rst_in)
        (s_r.st == DMD_ST_DONE && string_dst) |=> (seg_out == `DMD_SEG_EXTRA);
    endproperty
    a_seg_force: assert property (p_seg_force) else $error("string dest not extra");

    property p_table;
        @(posedge core_clk_in) disable iff (rst_in)
        (s_r.st == DMD_ST_DONE && s_r.op == `DMD_OP_TABLE_LOOK) |=> (decode_out.clocks == 8'd15);
    endproperty
    a_table: assert property (p_table) else $error("table lookup clocks wrong");

    property p_far_reg;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_out && (opcode_out == `DMD_OP_FAR_DATA) && !decode_out.is_mem) |-> illegal_out;
    endproperty
    a_far_reg: assert property (p_far_reg) else $error("far load reg form accepted");

    property p_push_all;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_out && opcode_out == `DMD_OP_PUSH_ALL) |-> (decode_out.clocks == 8'd68);
    endproperty
    a_push_all: assert property (p_push_all) else $error("push all clocks wrong");

    property p_ofs_load;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_out && opcode_out == `DMD_OP_LOAD_OFS) |-> (decode_out.clocks == 8'd6);
    endproperty
    a_ofs_load: assert property (p_ofs_load) else $error("offset load clocks wrong");

    property p_done_pulse;
        @(posedge core_clk_in) disable iff (rst_in)
        done_out |=> !done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held over");

    property p_ahf;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_out && opcode_out == `DMD_OP_HI_TO_FLAGS) |-> (decode_out.clocks == 8'd3);
    endproperty
    a_ahf: assert property (p_ahf) else $error("flag load clocks wrong");

    property p_pop_flags;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_out && opcode_out == `DMD_OP_POP_FLAGS) |-> (decode_out.clocks == 8'd12);
    endproperty
    a_pop_flags: assert property (p_pop_flags) else $error("pop flags clocks wrong");
endmodule

// File: tb/tb.sv
// Self-checking bench for the data-move decoder, driven at the falling clock edge
`timescale 1ns/1ns
module tb;
    import dmd_pkg::*;

`define CHK(nm, e, g) \
    begin \
        checks = checks + 1; \
        if ((g) !== (e)) begin \
            fails = fails + 1; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end

    // Byte lists packed first-entry-on-top; flat vectors keep free simulators happy
    localparam logic [55:0] FX_OP  = 56'hD79F9E9C9D6061;
    localparam logic [55:0] FX_CLK = 56'h0F02030D0C4453;
    localparam logic [31:0] PFX    = 32'h262E363E;

    logic        core_clk_in;
    logic        rst_in;
    logic        byte_valid_in;
    logic [7:0]  byte_in;
    dmd_regs_t   regs_in;
    logic        byte_ready_out;
    logic        done_out;
    dmd_decode_t decode_out;
    logic [7:0]  opcode_out;
    logic [3:0]  reg_code_out;
    logic [1:0]  seg_out;
    logic [15:0] offset_out;
    logic        illegal_out;
    int          fails;
    int          checks;

    dmd_decoder dut (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .byte_valid_in  (byte_valid_in),
        .byte_in        (byte_in),
        .regs_in        (regs_in),
        .byte_ready_out (byte_ready_out),
        .done_out       (done_out),
        .decode_out     (decode_out),
        .opcode_out     (opcode_out),
        .reg_code_out   (reg_code_out),
        .seg_out        (seg_out),
        .offset_out     (offset_out),
        .illegal_out    (illegal_out)
    );

    initial core_clk_in = 1'b0;
    always #5 core_clk_in = ~core_clk_in;

    task tally_and_finish;
        begin
            if (fails == 0 && checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    // Offers n bytes, first byte in the top of the vector, then waits for the result pulse
    task automatic run(input int n, input logic [39:0] bytes);
        int i;
        int k;
        begin
            for (i = 0; i < n; i++) begin
                @(negedge core_clk_in);
                byte_valid_in = 1'b1;
                byte_in = bytes[39-8*i -: 8];
                k = 0;
                while (byte_ready_out !== 1'b1 && k < 8) begin
                    @(negedge core_clk_in);
                    k++;
                end
                @(posedge core_clk_in);
            end
            @(negedge core_clk_in);
            byte_valid_in = 1'b0;
            byte_in = 8'hFF;
            `CHK("ready_in_done", 1'b0, byte_ready_out)
            k = 0;
            while (done_out !== 1'b1 && k < 6) begin
                @(negedge core_clk_in);
                k++;
            end
            `CHK("done_seen", 1'b1, done_out)
            @(negedge core_clk_in);
            // Done must drop again after its one-cycle pulse
            `CHK("done_pulse", 1'b0, done_out)
        end
    endtask

    task automatic t_seg_moves;
        begin
            run(2, 40'h8ED8000000);
            `CHK("clocks", 8'h02, decode_out.clocks)
            `CHK("illegal", 1'b0, illegal_out)
            run(4, 40'h8E06341200);
            `CHK("clocks", 8'h0D, decode_out.clocks)
            `CHK("offset", 16'h1234, offset_out)
            `CHK("opcode", 8'h8E, opcode_out)
            run(3, 40'h8C46080000);
            `CHK("clocks", 8'h0F, decode_out.clocks)
            `CHK("offset", 16'h2008, offset_out)
            `CHK("seg", 2'h2, seg_out)
        end
    endtask

    task automatic t_fixed_counts;
        int i;
        begin
            for (i = 0; i < 7; i++) begin
                run(1, {FX_OP[55-8*i -: 8], 32'h0});
                `CHK("clocks", FX_CLK[55-8*i -: 8], decode_out.clocks)
                `CHK("opcode", FX_OP[55-8*i -: 8], opcode_out)
                `CHK("illegal", 1'b0, illegal_out)
            end
            // Immediate data bytes are not part of the decoded stream
            run(1, 40'h6B00000000);
            `CHK("clocks", 8'h0E, decode_out.clocks)
            `CHK("illegal", 1'b0, illegal_out)
            run(1, 40'h6900000000);
            `CHK("clocks", 8'h0E, decode_out.clocks)
            run(1, 40'hA100000000);
            `CHK("clocks", 8'h0C, decode_out.clocks)
            run(1, 40'hE500000000);
            `CHK("clocks", 8'h0E, decode_out.clocks)
            run(1, 40'h0F00000000);
            `CHK("illegal", 1'b1, illegal_out)
            run(1, 40'h1F00000000);
            `CHK("illegal", 1'b0, illegal_out)
            `CHK("clocks", 8'h0C, decode_out.clocks)
        end
    endtask

    task automatic t_offset_and_far;
        begin
            run(4, 40'h8D80CDAB00);
            `CHK("clocks", 8'h06, decode_out.clocks)
            `CHK("offset", 16'hBBFD, offset_out)
            // Negative byte displacement must be sign-extended before the add
            run(3, 40'hC547F00000);
            `CHK("clocks", 8'h1A, decode_out.clocks)
            `CHK("offset", 16'h0FF0, offset_out)
            `CHK("illegal", 1'b0, illegal_out)
            run(4, 40'hC41E003000);
            `CHK("clocks", 8'h1A, decode_out.clocks)
            `CHK("offset", 16'h3000, offset_out)
            `CHK("seg", 2'h3, seg_out)
            run(2, 40'hC5C0000000);
            `CHK("illegal", 1'b1, illegal_out)
            run(2, 40'hC4C3000000);
            `CHK("illegal", 1'b1, illegal_out)
        end
    endtask

    task automatic t_override_and_regs;
        int i;
        begin
            for (i = 0; i < 4; i++) begin
                run(3, {PFX[31-8*i -: 8], 32'h8A270000});
                `CHK("seg", i[1:0], seg_out)
                `CHK("offset", 16'h1000, offset_out)
                `CHK("reg_code", 4'h4, reg_code_out)
                `CHK("clocks", 8'h09, decode_out.clocks)
            end
            // Prefix must not leak into the next instruction
            run(3, 40'h8A46000000);
            `CHK("seg", 2'h2, seg_out)
            `CHK("offset", 16'h2000, offset_out)
            run(2, 40'h8B2F000000);
            `CHK("reg_code", 4'hD, reg_code_out)
            `CHK("clocks", 8'h0D, decode_out.clocks)
            run(2, 40'h8BC1000000);
            `CHK("reg_code", 4'h8, reg_code_out)
            `CHK("clocks", 8'h02, decode_out.clocks)
            run(3, 40'h8943020000);
            `CHK("offset", 16'h2402, offset_out)
            `CHK("seg", 2'h2, seg_out)
            `CHK("clocks", 8'h10, decode_out.clocks)
            run(2, 40'h8803000000);
            `CHK("offset", 16'h2400, offset_out)
            `CHK("seg", 2'h2, seg_out)
            `CHK("clocks", 8'h0C, decode_out.clocks)
        end
    endtask

    task automatic t_string_dest;
        begin
            run(2, 40'h3EA4000000);
            `CHK("seg", 2'h0, seg_out)
            run(2, 40'h2EAB000000);
            `CHK("seg", 2'h0, seg_out)
        end
    endtask

    initial begin
        fails = 0;
        checks = 0;
        rst_in = 1'b1;
        byte_valid_in = 1'b0;
        byte_in = 8'h00;
        // Order: bx, base pointer, si, destination index
        regs_in = {16'h1000, 16'h2000, 16'h0030, 16'h0400};
        repeat (12) @(posedge core_clk_in);
        @(negedge core_clk_in);
        `CHK("done_in_reset", 1'b0, done_out)
        rst_in = 1'b0;
        t_seg_moves();
        t_fixed_counts();
        t_offset_and_far();
        t_override_and_regs();
        t_string_dest();
        tally_and_finish();
    end

    // About 35 instructions of under 12 cycles each; this span is more than ten times that
    initial begin
        #50000;
        fails = fails + 1;
        tally_and_finish();
    end
endmodule
